/* File: hdl/cpu_slice.sv */
// Decode and execution sequencer for one slice of an 8-bit processor's instruction set.
//
// How it works
// - Add-with-carry sums operand, accumulator and carry; sets N Z C V.
// - Indexed absolute and indirect-indexed reads add a cycle on page crossing.
// - AND combines operand with accumulator; only N and Z change.
// - Carry-clear branches on C=0, carry-set branches on C=1.
// - Equal branches on Z=1, not-equal branches on Z=0.
// - Negative branches on N=1, positive branches on N=0.
// - Overflow-clear branches on V=0, overflow-set on V=1.
// - Branch: 2 cycles untaken, 3 taken same page, 4 across pages.
// - Branches are two bytes, relative, and never alter status flags.
// - Bit test copies operand bit 7 to N and bit 6 to V.
// - Bit test sets Z from A AND M, keeps A; 3 or 4 cycles.
// - Break is one byte, seven cycles, pushes PC+2 then status.
// - Break runs whatever the interrupt disable flag says.
// - Clear-carry zeroes C and leaves other flags alone.
`timescale 1ns/100ps
`default_nettype none

module cpu_slice
	import cpu_slice_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  memRdData,
	input  wire logic [7:0]  xIndex,
	input  wire logic [7:0]  yIndex,
	output logic      [15:0] memAddr,
	output logic      [7:0]  memWrData,
	output logic             memWe,
	output logic      [7:0]  accOut,
	output logic      [7:0]  statusOut,
	output logic      [15:0] pcOut,
	output logic      [7:0]  stackOut,
	output logic             instrDone
);

	// ==========================================================
	// Decode and arithmetic helpers
	function automatic dec_s decode(input logic [7:0] o);
		dec_s d;
		d.kind = K_NOP;
		d.mode = M_IMP;
		if (o[4:0] == BRANCH_LOW) begin
			d.kind = K_BR;
			d.mode = M_REL;
		end else if (o == OP_BRK) begin
			d.kind = K_BRK;
		end else if (o == OP_CLC) begin
			d.kind = K_CLC;
		end else if (o == OP_BIT_ZP || o == OP_BIT_ABS) begin
			d.kind = K_BIT;
			d.mode = o[3] ? M_ABS : M_ZP;
		end else if (o[1:0] == 2'h1 && (o[7:5] == GRP_ADC || o[7:5] == GRP_AND)) begin
			d.kind = (o[7:5] == GRP_ADC) ? K_ADC : K_AND;
			case (o[4:2])
				3'h0: d.mode = M_INDX;
				3'h1: d.mode = M_ZP;
				3'h2: d.mode = M_IMM;
				3'h3: d.mode = M_ABS;
				3'h4: d.mode = M_INDY;
				3'h5: d.mode = M_ZPX;
				3'h6: d.mode = M_ABSY;
				default: d.mode = M_ABSX;
			endcase
		end else if (o[1:0] == 2'h2 && o[7:5] == GRP_ASL) begin
			d.kind = K_ASL;
			case (o[4:2])
				3'h1: d.mode = M_ZP;
				3'h2: d.mode = M_ACC;
				3'h3: d.mode = M_ABS;
				3'h5: d.mode = M_ZPX;
				3'h7: d.mode = M_ABSX;
				default: d.kind = K_NOP;
			endcase
		end
		return d;
	endfunction

	function automatic logic taken(input logic [7:0] o, input logic [7:0] f);
		logic flag;
		case (o[7:6])
			2'h0: flag = f[FLAG_N];
			2'h1: flag = f[FLAG_V];
			2'h2: flag = f[FLAG_C];
			default: flag = f[FLAG_Z];
		endcase
		return flag == o[5];
	endfunction

	function automatic alu_s exec(input kind_t k, input logic [7:0] a, input logic [7:0] p,
			input logic [7:0] m);
		alu_s r;
		logic [8:0] sum;
		logic [7:0] ovf;
		r.a = a;
		r.p = p;
		r.res = m;
		sum = {1'b0, a} + {1'b0, m} + {8'h00, p[FLAG_C]};
		ovf = ~(a ^ m) & (a ^ sum[7:0]);
		case (k)
			K_ADC: begin
				r.a = sum[7:0];
				r.p[FLAG_C] = sum[8];
				r.p[FLAG_V] = ovf[7];
				r.p[FLAG_N] = sum[7];
				r.p[FLAG_Z] = (sum[7:0] == 8'h00);
			end
			K_AND: begin
				r.a = a & m;
				r.p[FLAG_N] = r.a[7];
				r.p[FLAG_Z] = (r.a == 8'h00);
			end
			K_BIT: begin
				r.p[FLAG_N] = m[7];
				r.p[FLAG_V] = m[6];
				r.p[FLAG_Z] = ((a & m) == 8'h00);
			end
			K_ASL: begin
				r.res = {m[6:0], 1'b0};
				r.p[FLAG_C] = m[7];
				r.p[FLAG_N] = m[6];
				r.p[FLAG_Z] = (m[6:0] == 7'h00);
			end
			K_CLC: r.p[FLAG_C] = 1'b0;
			default: r.p = p;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Sequencer
	state_s     q;
	state_s     n;
	dec_s       dec;
	dec_s       fdec;
	alu_s       exM;
	alu_s       exA;
	alu_s       exT;
	logic [8:0] idxSum;
	logic [15:0] tgt;

	always_comb begin
		n = q;
		dec = decode(q.op);
		fdec = decode(memRdData);
		exM = exec(dec.kind, q.a, q.p, memRdData);
		exA = exec(dec.kind, q.a, q.p, q.a);
		exT = exec(dec.kind, q.a, q.p, q.tmp);
		idxSum = {1'b0, q.tmp} + {1'b0, (dec.mode == M_ABSX) ? xIndex : yIndex};
		tgt = q.pc + {{8{q.tmp[7]}}, q.tmp};
		n.we = 1'b0;
		n.done = 1'b0;
		case (q.st)
			S_FETCH: begin
				n.op = memRdData;
				n.pc = q.pc + 16'h0001;
				n.addr = n.pc;
				n.st = (fdec.mode == M_IMP || fdec.mode == M_ACC) ? S_IMPL : S_OP1;
			end
			S_IMPL: begin
				if (dec.kind == K_BRK) begin
					// No test of the I flag here: break is never masked.
					n.pc = q.pc + 16'h0001;
					n.addr = {STACK_PAGE, q.s};
					n.wdata = n.pc[15:8];
					n.we = 1'b1;
					n.cnt = 2'h0;
					n.st = S_PSH;
				end else begin
					n.a = (dec.kind == K_ASL) ? exA.res : q.a;
					n.p = exA.p;
					n.addr = q.pc;
					n.done = 1'b1;
					n.st = S_FETCH;
				end
			end
			S_OP1: begin
				n.pc = q.pc + 16'h0001;
				n.addr = n.pc;
				n.ea = {8'h00, memRdData};
				n.tmp = memRdData;
				case (dec.mode)
					M_IMM: begin
						n.a = exM.a;
						n.p = exM.p;
						n.done = 1'b1;
						n.st = S_FETCH;
					end
					M_REL: begin
						n.st = taken(q.op, q.p) ? S_BRT : S_FETCH;
						n.done = ~taken(q.op, q.p);
					end
					M_ZP: begin
						n.addr = n.ea;
						n.st = S_READ;
					end
					M_ZPX, M_INDX: begin
						n.addr = n.ea;
						n.st = S_IDX;
					end
					M_INDY: begin
						n.addr = n.ea;
						n.st = S_PLO;
					end
					M_ABS, M_ABSX, M_ABSY: n.st = S_OP2;
					default: begin
						n.done = 1'b1;
						n.st = S_FETCH;
					end
				endcase
			end
			S_IDX: begin
				n.ea = {8'h00, q.ea[7:0] + xIndex};
				n.addr = n.ea;
				n.st = (dec.mode == M_INDX) ? S_PLO : S_READ;
			end
			S_PLO: begin
				n.tmp = memRdData;
				n.addr = {8'h00, q.ea[7:0] + 8'h01};
				n.st = S_PHI;
			end
			S_OP2, S_PHI: begin
				n.pc = (q.st == S_OP2) ? q.pc + 16'h0001 : q.pc;
				if (dec.mode == M_ABS || dec.mode == M_INDX) begin
					n.ea = {memRdData, q.tmp};
					n.st = S_READ;
				end else begin
					// Read-modify-write always spends the fix-up cycle.
					n.ea = {memRdData, idxSum[7:0]};
					n.cnt = {1'b0, idxSum[8]};
					n.st = (idxSum[8] || dec.kind == K_ASL) ? S_FIX : S_READ;
				end
				n.addr = n.ea;
			end
			S_FIX: begin
				n.ea[15:8] = q.ea[15:8] + {7'h00, q.cnt[0]};
				n.addr = n.ea;
				n.st = S_READ;
			end
			S_READ: begin
				if (dec.kind == K_ASL) begin
					n.tmp = memRdData;
					n.wdata = memRdData;
					n.we = 1'b1;
					n.st = S_MOD;
				end else begin
					n.a = exM.a;
					n.p = exM.p;
					n.addr = q.pc;
					n.done = 1'b1;
					n.st = S_FETCH;
				end
			end
			S_MOD: begin
				n.p = exT.p;
				n.wdata = exT.res;
				n.we = 1'b1;
				n.st = S_WRITE;
			end
			S_WRITE: begin
				n.addr = q.pc;
				n.done = 1'b1;
				n.st = S_FETCH;
			end
			S_BRT: begin
				n.ea = tgt;
				if (tgt[15:8] == q.pc[15:8]) begin
					n.pc = tgt;
					n.done = 1'b1;
					n.st = S_FETCH;
				end else begin
					n.pc = {q.pc[15:8], tgt[7:0]};
					n.st = S_BRF;
				end
				n.addr = n.pc;
			end
			S_BRF: begin
				n.pc = q.ea;
				n.addr = q.ea;
				n.done = 1'b1;
				n.st = S_FETCH;
			end
			S_PSH: begin
				n.s = q.s - 8'h01;
				n.cnt = q.cnt + 2'h1;
				n.addr = {STACK_PAGE, n.s};
				n.we = 1'b1;
				case (q.cnt)
					2'h0: n.wdata = q.pc[7:0];
					2'h1: n.wdata = q.p | PUSH_MASK;
					default: begin
						n.we = 1'b0;
						n.p[FLAG_I] = 1'b1;
						n.ea = BRK_VEC;
						n.addr = BRK_VEC;
						n.st = S_VLO;
					end
				endcase
			end
			S_VLO: begin
				n.tmp = memRdData;
				n.addr = q.ea + 16'h0001;
				n.st = S_VHI;
			end
			S_VHI: begin
				n.pc = {memRdData, q.tmp};
				n.addr = n.pc;
				n.done = 1'b1;
				n.st = S_FETCH;
			end
			default: begin
				n.addr = q.pc;
				n.st = S_FETCH;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= STATE_RESET;
		end else begin
			q <= n;
		end
	end

	assign memAddr   = q.addr;
	assign memWrData = q.wdata;
	assign memWe     = q.we;
	assign accOut    = q.a;
	assign statusOut = q.p;
	assign pcOut     = q.pc;
	assign stackOut  = q.s;
	assign instrDone = q.done;

	// ==========================================================
	// Checks
	logic [8:0] adcRef;
	logic [7:0] andRef;
	assign adcRef = {1'b0, q.a} + {1'b0, memRdData} + {8'h00, q.p[FLAG_C]};
	assign andRef = q.a & memRdData;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence brkTail;
		q.st == S_PSH [*3] ##1 q.st == S_VLO ##1 q.st == S_VHI ##1 q.st == S_FETCH;
	endsequence

	brk_sequence_a: assert property (q.st == S_FETCH && memRdData == OP_BRK |=>
		q.st == S_IMPL ##1 brkTail) else $error("break sequence length wrong");
	brk_stack_a: assert property (q.st == S_IMPL && q.op == OP_BRK |=>
		memWe && memWrData == q.pc[15:8] ##1 memWe && memWrData == q.pc[7:0])
		else $error("break pushed wrong return address");
	brk_vector_a: assert property (q.st == S_PSH && q.cnt == BRK_PUSHES |=>
		statusOut[FLAG_I] && memAddr == BRK_VEC ##1 memAddr == BRK_VEC + 16'h0001)
		else $error("break vector fetch wrong");
	adc_sum_a: assert property (q.st == S_READ && dec.kind == K_ADC |=>
		{statusOut[FLAG_C], accOut} == $past(adcRef)) else $error("add result wrong");
	and_only_nz_a: assert property (q.st == S_READ && dec.kind == K_AND |=>
		accOut == $past(andRef) && statusOut[6:2] == $past(q.p[6:2])
		&& statusOut[FLAG_C] == $past(q.p[FLAG_C])) else $error("and result wrong");
	page_cross_a: assert property (q.st == S_OP2 && dec.kind != K_ASL
		&& (dec.mode == M_ABSX || dec.mode == M_ABSY) && idxSum[8]
		|=> q.st == S_FIX ##1 q.st == S_READ) else $error("missing page cycle");
	asl_write_a: assert property (q.st == S_MOD |=> memWe
		&& memWrData == {$past(q.tmp[6:0]), 1'b0} && statusOut[FLAG_C] == $past(q.tmp[7]))
		else $error("shift result wrong");
	bit_test_a: assert property (q.st == S_READ && dec.kind == K_BIT |=>
		accOut == $past(q.a) && statusOut[FLAG_N] == $past(memRdData[7])
		&& statusOut[FLAG_V] == $past(memRdData[6])
		&& statusOut[FLAG_Z] == ($past(andRef) == 8'h00)) else $error("bit test wrong");
	branch_flags_a: assert property (q.st == S_OP1 && dec.mode == M_REL |=>
		$stable(statusOut) [*2]) else $error("branch changed flags");
	carry_branch_a: assert property (q.st == S_OP1 && (q.op == OP_BCC || q.op == OP_BCS)
		|=> (q.st == S_BRT) == ($past(q.p[FLAG_C]) == $past(q.op[5])))
		else $error("carry branch wrong");
	zero_branch_a: assert property (q.st == S_OP1 && (q.op == OP_BEQ || q.op == OP_BNE)
		|=> (q.st == S_BRT) == ($past(q.p[FLAG_Z]) == $past(q.op[5])))
		else $error("zero branch wrong");
	neg_branch_a: assert property (q.st == S_OP1 && (q.op == OP_BMI || q.op == OP_BPL)
		|=> (q.st == S_BRT) == ($past(q.p[FLAG_N]) == $past(q.op[5])))
		else $error("negative branch wrong");
	ovf_branch_a: assert property (q.st == S_OP1 && (q.op == OP_BVC || q.op == OP_BVS)
		|=> (q.st == S_BRT) == ($past(q.p[FLAG_V]) == $past(q.op[5])))
		else $error("overflow branch wrong");
	branch_time_a: assert property (q.st == S_BRT |=> q.st == S_FETCH
		or (q.st == S_BRF ##1 q.st == S_FETCH)) else $error("branch time wrong");
	clc_flags_a: assert property (q.st == S_IMPL && q.op == OP_CLC |=>
		!statusOut[FLAG_C] && statusOut[7:1] == $past(q.p[7:1])) else $error("clear carry wrong");

endmodule

`default_nettype wire

/* File: hdl/cpu_slice_pkg.sv */
// Constants, encodings and state record shared by the instruction slice.
package cpu_slice_pkg;

	// ==========================================================
	// Sequencer states
	typedef enum logic [15:0] {
		S_FETCH = 16'h0001,
		S_IMPL  = 16'h0002,
		S_OP1   = 16'h0004,
		S_OP2   = 16'h0008,
		S_IDX   = 16'h0010,
		S_PLO   = 16'h0020,
		S_PHI   = 16'h0040,
		S_FIX   = 16'h0080,
		S_READ  = 16'h0100,
		S_MOD   = 16'h0200,
		S_WRITE = 16'h0400,
		S_BRT   = 16'h0800,
		S_BRF   = 16'h1000,
		S_PSH   = 16'h2000,
		S_VLO   = 16'h4000,
		S_VHI   = 16'h8000
	} state_e;

	// ==========================================================
	// Operation kinds and addressing modes
	typedef logic [2:0] kind_t;
	typedef logic [3:0] mode_t;
	localparam kind_t K_NOP = 3'h0;
	localparam kind_t K_ADC = 3'h1;
	localparam kind_t K_AND = 3'h2;
	localparam kind_t K_BIT = 3'h3;
	localparam kind_t K_ASL = 3'h4;
	localparam kind_t K_BR  = 3'h5;
	localparam kind_t K_BRK = 3'h6;
	localparam kind_t K_CLC = 3'h7;
	localparam mode_t M_IMP  = 4'h0;
	localparam mode_t M_IMM  = 4'h1;
	localparam mode_t M_ZP   = 4'h2;
	localparam mode_t M_ZPX  = 4'h3;
	localparam mode_t M_ABS  = 4'h4;
	localparam mode_t M_ABSX = 4'h5;
	localparam mode_t M_ABSY = 4'h6;
	localparam mode_t M_INDX = 4'h7;
	localparam mode_t M_INDY = 4'h8;
	localparam mode_t M_ACC  = 4'h9;
	localparam mode_t M_REL  = 4'ha;

	// ==========================================================
	// Opcodes and opcode fields
	localparam logic [7:0] OP_BRK     = 8'h00;
	localparam logic [7:0] OP_CLC     = 8'h18;
	localparam logic [7:0] OP_BIT_ZP  = 8'h24;
	localparam logic [7:0] OP_BIT_ABS = 8'h2c;
	localparam logic [7:0] OP_BCC     = 8'h90;
	localparam logic [7:0] OP_BCS     = 8'hb0;
	localparam logic [7:0] OP_BEQ     = 8'hf0;
	localparam logic [7:0] OP_BNE     = 8'hd0;
	localparam logic [7:0] OP_BMI     = 8'h30;
	localparam logic [7:0] OP_BPL     = 8'h10;
	localparam logic [7:0] OP_BVC     = 8'h50;
	localparam logic [7:0] OP_BVS     = 8'h70;
	localparam logic [4:0] BRANCH_LOW = 5'h10;
	localparam logic [2:0] GRP_ADC    = 3'h3;
	localparam logic [2:0] GRP_AND    = 3'h1;
	localparam logic [2:0] GRP_ASL    = 3'h0;

	// ==========================================================
	// Status bits, vectors, reset values
	localparam int FLAG_N = 7;
	localparam int FLAG_V = 6;
	localparam int FLAG_I = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;
	localparam logic [7:0]  PUSH_MASK  = 8'h30;
	localparam logic [7:0]  STACK_PAGE = 8'h01;
	localparam logic [15:0] RESET_VEC  = 16'hfffc;
	localparam logic [15:0] BRK_VEC    = 16'hfffe;
	localparam logic [1:0]  BRK_PUSHES = 2'h2;

	typedef struct packed {
		kind_t kind;
		mode_t mode;
	} dec_s;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] p;
		logic [7:0] res;
	} alu_s;

	typedef struct packed {
		state_e      st;
		logic [15:0] pc;
		logic [7:0]  a;
		logic [7:0]  s;
		logic [7:0]  p;
		logic [7:0]  op;
		logic [15:0] ea;
		logic [7:0]  tmp;
		logic [1:0]  cnt;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        done;
	} state_s;

	localparam state_s STATE_RESET = '{st: S_VLO, pc: 16'h0000, a: 8'h00, s: 8'hfd,
		p: 8'h34, op: 8'h00, ea: RESET_VEC, tmp: 8'h00, cnt: 2'h0, addr: RESET_VEC,
		wdata: 8'h00, we: 1'b0, done: 1'b0};

endpackage

/* File: dv/mem_model.sv */
// Behavioural memory with asynchronous read and clocked write standing on the slice's bus.
`timescale 1ns/100ps
`default_nettype none

module mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWrData,
	input  wire logic        memWe,
	output logic      [7:0]  memRdData
);
	// ==========================================================
	// Storage
	// Untouched cells hold a scrambled pattern so a stray read shows up.
	logic [7:0] mem [0:65535];

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end

	assign memRdData = mem[memAddr];

	always @(posedge clk) begin
		if (memWe) begin
			mem[memAddr] <= memWrData;
		end
	end
endmodule
`default_nettype wire

/* File: dv/tb_cpu_slice.sv */
// Self-checking random bench for the instruction slice.
`timescale 1ns/100ps
`default_nettype none

module tb_cpu_slice
	import cpu_slice_pkg::*;
;
	// ==========================================================
	// Signals
	logic        clk;
	logic        rst_n;
	logic [7:0]  xIndex;
	logic [7:0]  yIndex;
	logic [7:0]  memRdData;
	logic [15:0] memAddr;
	logic [7:0]  memWrData;
	logic        memWe;
	logic [7:0]  accOut;
	logic [7:0]  statusOut;
	logic [15:0] pcOut;
	logic [7:0]  stackOut;
	logic        instrDone;
	int          errors;
	int          comparisons;
	int          n;
	logic [31:0] r;
	logic [7:0]  m;
	logic [7:0]  expA;
	logic [7:0]  expP;
	logic [15:0] pc;
	logic [15:0] ea;
	logic [15:0] fallThru;
	int          cycles;
	localparam logic [7:0] BR_OP [8] = '{OP_BCC, OP_BCS, OP_BEQ, OP_BNE,
		OP_BMI, OP_BPL, OP_BVC, OP_BVS};
	localparam int BR_BIT [8] = '{FLAG_C, FLAG_C, FLAG_Z, FLAG_Z, FLAG_N, FLAG_N, FLAG_V, FLAG_V};
	localparam logic [7:0] BR_WANT = 8'h96;

	cpu_slice cpu_slice_i (
		.clk       (clk),
		.rst_n     (rst_n),
		.memRdData (memRdData),
		.xIndex    (xIndex),
		.yIndex    (yIndex),
		.memAddr   (memAddr),
		.memWrData (memWrData),
		.memWe     (memWe),
		.accOut    (accOut),
		.statusOut (statusOut),
		.pcOut     (pcOut),
		.stackOut  (stackOut),
		.instrDone (instrDone)
	);

	mem_model mem_model_i (
		.clk       (clk),
		.memAddr   (memAddr),
		.memWrData (memWrData),
		.memWe     (memWe),
		.memRdData (memRdData)
	);

	// ==========================================================
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic put(input logic [15:0] a, input logic [7:0] v);
		mem_model_i.mem[a] = v;
	endtask

	function automatic logic [15:0] peek(input logic [15:0] a);
		return {8'h00, mem_model_i.mem[a]};
	endfunction

	function automatic logic [7:0] nz(input logic [7:0] p, input logic [7:0] v);
		logic [7:0] q;
		q = p;
		q[FLAG_N] = v[7];
		q[FLAG_Z] = (v == 8'h00);
		return q;
	endfunction

	// Cycles are counted from the fetch marker of one instruction to the next.
	task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
		input int cyc, input logic [15:0] nxt);
		int k;
		k = 0;
		put(pc, b0);
		put(pc + 16'h0001, b1);
		put(pc + 16'h0002, b2);
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (instrDone !== 1'b1 && k < 40);
		if (k >= 40) begin
			errors++;
			summarize();
		end
		check(16'(k), 16'(cyc));
		check(memAddr, nxt);
		check(pcOut, nxt);
		check({8'h00, accOut}, {8'h00, expA});
		check({8'h00, statusOut}, {8'h00, expP});
		pc = nxt;
	endtask

	task automatic adc(input logic [7:0] v);
		logic [8:0] s;
		s = {1'b0, expA} + {1'b0, v} + {8'h00, expP[FLAG_C]};
		expP = nz(expP, s[7:0]);
		expP[FLAG_C] = s[8];
		expP[FLAG_V] = (expA[7] == v[7]) && (s[7] != expA[7]);
		expA = s[7:0];
	endtask

	task automatic shl(input logic [7:0] v);
		expP = nz(expP, {v[6:0], 1'b0});
		expP[FLAG_C] = v[7];
	endtask

	// ==========================================================
	// Stimulus
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		errors = 0;
		comparisons = 0;
		rst_n = 1'b0;
		xIndex = 8'h00;
		yIndex = 8'h00;
		void'($urandom(37));
		// The memory model fills every cell at time zero, so the vectors go in after it.
		#1;
		put(16'hfffc, 8'h00);
		put(16'hfffd, 8'h08);
		put(16'hfffe, 8'h00);
		put(16'hffff, 8'h0a);
		repeat (4) @(posedge clk);
		#1;
		check({8'h00, statusOut}, 16'h0034);
		check({8'h00, stackOut}, 16'h00fd);
		check(memAddr, RESET_VEC);
		check({15'h0000, memWe}, 16'h0000);
		check(pcOut, 16'h0000);
		rst_n = 1'b1;
		n = 0;
		while (instrDone !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20) begin
			errors++;
			summarize();
		end
		pc = 16'h0800;
		check(memAddr, pc);
		expA = 8'h00;
		expP = 8'h34;
		adc(8'hc5);
		issue(8'h69, 8'hc5, 8'h00, 2, 16'h0802);
		// The stack page is kept away from code so the stack pushes land in free cells.
		m = expP | 8'h30;
		expP[FLAG_I] = 1'b1;
		issue(OP_BRK, 8'h00, 8'h00, 7, 16'h0a00);
		check(peek(16'h01fd), 16'h0008);
		check(peek(16'h01fc), 16'h0004);
		check(peek(16'h01fb), {8'h00, m});
		check({8'h00, stackOut}, 16'h00fa);
		for (int i = 0; i < 300; i++) begin
			r = $urandom;
			m = r[15:8];
			xIndex = r[23:16];
			yIndex = r[31:24];
			ea = 16'h30f0 + {8'h00, xIndex};
			case (r % 12)
				0: begin
					adc(m);
					issue(8'h69, m, 8'h00, 2, pc + 16'h0002);
				end
				1: begin
					expA = expA & m;
					expP = nz(expP, expA);
					issue(8'h29, m, 8'h00, 2, pc + 16'h0002);
				end
				2: begin
					put(16'h0040, m);
					put(16'h3040, m);
					expP[FLAG_N] = m[7];
					expP[FLAG_V] = m[6];
					expP[FLAG_Z] = ((expA & m) == 8'h00);
					if (r[4]) begin
						issue(OP_BIT_ABS, 8'h40, 8'h30, 4, pc + 16'h0003);
					end else begin
						issue(OP_BIT_ZP, 8'h40, 8'h00, 3, pc + 16'h0002);
					end
				end
				3, 4: begin
					n = int'(r[26:24]);
					fallThru = pc + 16'h0002;
					ea = fallThru + {{8{m[7]}}, m};
					cycles = (ea[15:8] == fallThru[15:8]) ? 3 : 4;
					if (expP[BR_BIT[n]] == BR_WANT[n]) begin
						issue(BR_OP[n], m, 8'h00, cycles, ea);
					end else begin
						issue(BR_OP[n], m, 8'h00, 2, fallThru);
					end
				end
				5: begin
					expP[FLAG_C] = 1'b0;
					issue(OP_CLC, 8'h00, 8'h00, 2, pc + 16'h0001);
				end
				6: begin
					shl(expA);
					expA = {expA[6:0], 1'b0};
					issue(8'h0a, 8'h00, 8'h00, 2, pc + 16'h0001);
				end
				7: begin
					ea = 16'h30f0 + {8'h00, r[5] ? yIndex : xIndex};
					put(ea, m);
					adc(m);
					cycles = (ea[15:8] != 8'h30) ? 5 : 4;
					issue(r[5] ? 8'h79 : 8'h7d, 8'hf0, 8'h30, cycles, pc + 16'h0003);
				end
				8: begin
					put(16'h0080, 8'hf0);
					put(16'h0081, 8'h30);
					ea = 16'h30f0 + {8'h00, yIndex};
					put(ea, m);
					adc(m);
					cycles = (ea[15:8] != 8'h30) ? 6 : 5;
					issue(8'h71, 8'h80, 8'h00, cycles, pc + 16'h0002);
				end
				9: begin
					// The pointer wraps inside page zero, as the index sum is only eight bits.
					put({8'h00, 8'h80 + xIndex}, 8'h00);
					put({8'h00, 8'h81 + xIndex}, 8'h32);
					put(16'h3200, m);
					expA = expA & m;
					expP = nz(expP, expA);
					issue(8'h21, 8'h80, 8'h00, 6, pc + 16'h0002);
				end
				10: begin
					ea = {8'h00, 8'h50 + xIndex};
					put(ea, m);
					shl(m);
					issue(8'h16, 8'h50, 8'h00, 6, pc + 16'h0002);
					check(peek(ea), {8'h00, m[6:0], 1'b0});
				end
				default: begin
					put(ea, m);
					shl(m);
					issue(8'h1e, 8'hf0, 8'h30, 7, pc + 16'h0003);
					check(peek(ea), {8'h00, m[6:0], 1'b0});
				end
			endcase
		end
		summarize();
	end
endmodule
`default_nettype wire
